// file: dual_timer_pkg.sv
// dual timer/counter package: register map, field positions, reset values
// and divider counts shared by the timer core and its helpers.
// assumes one 25 MHz oscillator clock drives everything.
package dual_timer_pkg;

  // unit count and count byte width
  localparam int NUM_UNITS = 2;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 4;

  // register offsets on the plain register port
  localparam logic [3:0] ADDR_TIMER_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_CLOCK_CTRL = 4'h2;
  localparam logic [3:0] ADDR_LOW0 = 4'h3;
  localparam logic [3:0] ADDR_HIGH0 = 4'h4;
  localparam logic [3:0] ADDR_LOW1 = 4'h5;
  localparam logic [3:0] ADDR_HIGH1 = 4'h6;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;

  // timer_control_reg fields: run at 4/6, overflow at 5/7
  localparam int RUN0_BIT = 4;
  localparam int OVF0_BIT = 5;
  localparam int UNIT_STRIDE = 2;
  // mode register fields: per unit counter select then gate enable
  localparam int SEL0_BIT = 0;
  localparam int GATE_ENABLE_BIT = 1;
  // clock_control_reg fields
  localparam int RATE0_BIT = 0;
  localparam int DOUBLE_BIT = 2;

  // reset values and the byte maximum
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] BYTE_MAX = 8'hFF;

  // last timer clock count of a peripheral cycle (six timer clocks per cycle)
  localparam logic [2:0] PER_DIV_LAST = 3'h5;
  // last oscillator phase of a timer clock when halved (two clocks per timer clock)
  localparam logic HALF_LAST = 1'h1;

endpackage

// file: pin_sync.sv
// three-stage pin synchroniser with agreement filter.
// assumes pins are asynchronous to clk; output moves once stages two
// and three agree, so a one-cycle glitch past stage one is dropped.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire clk,
  input wire rst_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinLevel
);

  // stage one is read only by stage two
  logic [WIDTH-1:0] stageOne;
  logic [WIDTH-1:0] stageTwo;
  logic [WIDTH-1:0] stageThree;
  logic [WIDTH-1:0] next_pinLevel;

  // filtered level follows only when the later stages agree
  always_comb begin
    next_pinLevel = pinLevel;
    for (int i = 0; i < WIDTH; i++) begin
      if (stageTwo[i] == stageThree[i]) begin
        next_pinLevel[i] = stageThree[i];
      end
    end
  end

  // synchroniser chain and filtered level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stageOne <= '0;
      stageTwo <= '0;
      stageThree <= '0;
      pinLevel <= '0;
    end else begin
      stageOne <= pinIn;
      stageTwo <= stageOne;
      stageThree <= stageTwo;
      pinLevel <= next_pinLevel;
    end
  end

endmodule

// file: unit_prescale.sv
// per-unit clock derivation: timer clock from the oscillator, then one
// peripheral-cycle tick every six timer clocks.
// assumes clk is the oscillator; rate bits are static while running.
`timescale 1ns/1ps
module unit_prescale (
  input wire clk,
  input wire rst_n,
  input wire logic rateSel,
  input wire logic doubleSpeed,
  output logic perTick
);

  // half-rate phase and the divide-by-six counter
  logic halfPhase;
  logic [2:0] perCount;
  logic timerTick;
  logic fullRate;
  logic next_halfPhase;
  logic [2:0] next_perCount;
  logic next_perTick;

  // timer clock enable and peripheral divider
  always_comb begin
    // undivided only in double-speed mode with the rate bit clear
    fullRate = doubleSpeed && !rateSel;
    timerTick = fullRate || (halfPhase == dual_timer_pkg::HALF_LAST);
    next_halfPhase = !halfPhase;
    next_perCount = perCount;
    next_perTick = 1'b0;
    if (timerTick) begin
      if (perCount == dual_timer_pkg::PER_DIV_LAST) begin
        next_perCount = 3'h0;
        next_perTick = 1'b1;
      end else begin
        next_perCount = perCount + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halfPhase <= 1'b0;
      perCount <= 3'h0;
      perTick <= 1'b0;
    end else begin
      halfPhase <= next_halfPhase;
      perCount <= next_perCount;
      perTick <= next_perTick;
    end
  end

  // double speed with the rate bit clear: six oscillator clocks per tick
  // only judged while the rate holds; software may switch it between ticks
  a_fast_rate: assert property (@(posedge clk) disable iff (!rst_n)
    (perTick && fullRate) ##1 fullRate [*5] |=> perTick)
    else $error("double-speed tick spacing wrong");

  // ticks never closer than six oscillator clocks, the shortest peripheral cycle
  a_tick_gap: assert property (@(posedge clk) disable iff (!rst_n)
    perTick |=> !perTick [*5])
    else $error("peripheral ticks too close");

endmodule

// file: dual_timer.sv
// dual 16-bit timer/counter with plain register port and interrupt.
// assumes a 25 MHz oscillator on clk and asynchronous count and gate
// pins; the processor pulses ovfAck when it vectors to a unit's handler.
//
// Overview of operation
// - two independent 16-bit timer or event counters
// - high and low count bytes chained
// - events bump low, carries high, overflow flags
// - starting a unit keeps its count bytes
// - count bytes readable at any time
// - select bit picks peripheral clock or pin
// - timer mode counts once per peripheral cycle
// - pin sampled per cycle, high-then-low counts
// - edge detection spans two peripheral cycles
// - rate bit picks oscillator half or mode-dependent
// - overflow raises interrupt in both operations
// - gate bit lets interrupt pin enable counting
// - flag set on overflow, cleared on vector
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module dual_timer (
  input wire clk,
  input wire rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [1:0] countPin,
  input wire logic [1:0] extIntPin,
  input wire logic [1:0] ovfAck,
  output logic [1:0] overflowFlag,
  output logic irq
);

  localparam int N = dual_timer_pkg::NUM_UNITS;

  // address compare used by every register write decode
  function automatic logic regHit(input logic [3:0] a, input logic [3:0] target);
    regHit = (a == target);
  endfunction

  // low/high byte addresses of a unit
  function automatic logic [3:0] lowAddr(input int u);
    lowAddr = (u == 0) ? dual_timer_pkg::ADDR_LOW0 : dual_timer_pkg::ADDR_LOW1;
  endfunction

  function automatic logic [3:0] highAddr(input int u);
    highAddr = (u == 0) ? dual_timer_pkg::ADDR_HIGH0 : dual_timer_pkg::ADDR_HIGH1;
  endfunction

  // synchronised pins: count pins low, gate pins high
  logic [3:0] pinLevel;
  logic [1:0] countLevel;
  logic [1:0] gateLevel;

  // peripheral-cycle tick per unit
  logic [1:0] perTick;

  // control state written by software
  logic [1:0] runCtl;
  logic [1:0] counterSel;
  logic [1:0] gateEn;
  logic [1:0] rateSel;
  logic doubleSpeed;
  logic [1:0] irqMask;
  logic [1:0] next_runCtl;
  logic [1:0] next_counterSel;
  logic [1:0] next_gateEn;
  logic [1:0] next_rateSel;
  logic next_doubleSpeed;
  logic [1:0] next_irqMask;

  // counting state
  logic [7:0] countLow [N];
  logic [7:0] countHigh [N];
  logic [1:0] prevSample;
  logic [1:0] irqStatus;
  logic [7:0] next_countLow [N];
  logic [7:0] next_countHigh [N];
  logic [1:0] next_prevSample;
  logic [1:0] next_overflowFlag;
  logic [1:0] next_irqStatus;
  logic next_irq;

  // per-unit decoded events
  logic [1:0] countEnable;
  logic [1:0] fallSeen;
  logic [1:0] incEvent;
  logic [1:0] ovfEvent;

  // read path
  logic [7:0] next_rdata;

  pin_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({extIntPin, countPin}),
    .pinLevel(pinLevel)
  );

  assign countLevel = pinLevel[1:0];
  assign gateLevel = pinLevel[3:2];

  // one clock divider per unit so rates stay independent
  // two separate units
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_unit
      unit_prescale u_prescale (
        .clk(clk),
        .rst_n(rst_n),
        .rateSel(rateSel[g]),
        .doubleSpeed(doubleSpeed),
        .perTick(perTick[g])
      );
    end
  endgenerate

  // control register writes
  always_comb begin
    next_runCtl = runCtl;
    next_counterSel = counterSel;
    next_gateEn = gateEn;
    next_rateSel = rateSel;
    next_doubleSpeed = doubleSpeed;
    next_irqMask = irqMask;
    if (wr && regHit(addr, dual_timer_pkg::ADDR_TIMER_CTRL)) begin
      // run bit only; count bytes untouched
      for (int u = 0; u < N; u++) begin
        next_runCtl[u] = wdata[dual_timer_pkg::RUN0_BIT + u * dual_timer_pkg::UNIT_STRIDE];
      end
    end
    if (wr && regHit(addr, dual_timer_pkg::ADDR_MODE)) begin
      for (int u = 0; u < N; u++) begin
        next_counterSel[u] = wdata[dual_timer_pkg::SEL0_BIT + u * dual_timer_pkg::UNIT_STRIDE];
        next_gateEn[u] = wdata[dual_timer_pkg::GATE_ENABLE_BIT + u * dual_timer_pkg::UNIT_STRIDE];
      end
    end
    if (wr && regHit(addr, dual_timer_pkg::ADDR_CLOCK_CTRL)) begin
      next_rateSel = wdata[dual_timer_pkg::RATE0_BIT +: 2];
      next_doubleSpeed = wdata[dual_timer_pkg::DOUBLE_BIT];
    end
    if (wr && regHit(addr, dual_timer_pkg::ADDR_IRQ_MASK)) begin
      next_irqMask = wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      runCtl <= dual_timer_pkg::CTRL_RESET;
      counterSel <= dual_timer_pkg::CTRL_RESET;
      gateEn <= dual_timer_pkg::CTRL_RESET;
      rateSel <= dual_timer_pkg::CTRL_RESET;
      doubleSpeed <= 1'b0;
      irqMask <= dual_timer_pkg::CTRL_RESET;
    end else begin
      runCtl <= next_runCtl;
      counterSel <= next_counterSel;
      gateEn <= next_gateEn;
      rateSel <= next_rateSel;
      doubleSpeed <= next_doubleSpeed;
      irqMask <= next_irqMask;
    end
  end

  // event decode, count chain, flags and interrupt status
  always_comb begin
    next_prevSample = prevSample;
    next_overflowFlag = overflowFlag;
    next_irqStatus = irqStatus;
    for (int u = 0; u < N; u++) begin
      // gate lets the interrupt pin hold counting off
      countEnable[u] = runCtl[u] && (!gateEn[u] || gateLevel[u]);
      // high sample then low sample one cycle later
      fallSeen[u] = prevSample[u] && !countLevel[u];
      // source select: tick itself or a pin falling edge
      incEvent[u] = perTick[u] && countEnable[u] && (!counterSel[u] || fallSeen[u]);
      // overflow only when both bytes roll over
      ovfEvent[u] = incEvent[u] && (countLow[u] == dual_timer_pkg::BYTE_MAX)
        && (countHigh[u] == dual_timer_pkg::BYTE_MAX);
      if (perTick[u]) begin
        next_prevSample[u] = countLevel[u];
      end
      next_countLow[u] = countLow[u];
      next_countHigh[u] = countHigh[u];
      // low byte counts, its carry steps the high byte
      if (incEvent[u]) begin
        next_countLow[u] = countLow[u] + 8'h01;
        if (countLow[u] == dual_timer_pkg::BYTE_MAX) begin
          next_countHigh[u] = countHigh[u] + 8'h01;
        end
      end
      // preset writes; result is only defined while stopped
      if (wr && regHit(addr, lowAddr(u))) begin
        next_countLow[u] = wdata;
      end
      if (wr && regHit(addr, highAddr(u))) begin
        next_countHigh[u] = wdata;
      end
      // vector clears the flag, a same-cycle overflow wins
      if (ovfAck[u]) begin
        next_overflowFlag[u] = 1'b0;
      end
      if (ovfEvent[u]) begin
        next_overflowFlag[u] = 1'b1;
      end
      // sticky status, write one to clear, set wins
      if (wr && regHit(addr, dual_timer_pkg::ADDR_IRQ_STATUS) && wdata[u]) begin
        next_irqStatus[u] = 1'b0;
      end
      if (ovfEvent[u]) begin
        next_irqStatus[u] = 1'b1;
      end
    end
    next_irq = |(next_irqStatus & irqMask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int u = 0; u < N; u++) begin
        countLow[u] <= dual_timer_pkg::COUNT_RESET;
        countHigh[u] <= dual_timer_pkg::COUNT_RESET;
      end
      prevSample <= 2'h0;
      overflowFlag <= 2'h0;
      irqStatus <= 2'h0;
      irq <= 1'b0;
    end else begin
      for (int u = 0; u < N; u++) begin
        countLow[u] <= next_countLow[u];
        countHigh[u] <= next_countHigh[u];
      end
      prevSample <= next_prevSample;
      overflowFlag <= next_overflowFlag;
      irqStatus <= next_irqStatus;
      irq <= next_irq;
    end
  end

  // register read mux; data valid in the cycle after rd only
  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        dual_timer_pkg::ADDR_TIMER_CTRL: begin
          for (int u = 0; u < N; u++) begin
            next_rdata[dual_timer_pkg::RUN0_BIT + u * dual_timer_pkg::UNIT_STRIDE] = runCtl[u];
            next_rdata[dual_timer_pkg::OVF0_BIT + u * dual_timer_pkg::UNIT_STRIDE] =
              overflowFlag[u];
          end
        end
        dual_timer_pkg::ADDR_MODE: begin
          for (int u = 0; u < N; u++) begin
            next_rdata[dual_timer_pkg::SEL0_BIT + u * dual_timer_pkg::UNIT_STRIDE] = counterSel[u];
            next_rdata[dual_timer_pkg::GATE_ENABLE_BIT + u * dual_timer_pkg::UNIT_STRIDE] = gateEn[u];
          end
        end
        dual_timer_pkg::ADDR_CLOCK_CTRL: begin
          next_rdata[dual_timer_pkg::RATE0_BIT +: 2] = rateSel;
          next_rdata[dual_timer_pkg::DOUBLE_BIT] = doubleSpeed;
        end
        // live count bytes, running or not
        dual_timer_pkg::ADDR_LOW0: next_rdata = countLow[0];
        dual_timer_pkg::ADDR_HIGH0: next_rdata = countHigh[0];
        dual_timer_pkg::ADDR_LOW1: next_rdata = countLow[1];
        dual_timer_pkg::ADDR_HIGH1: next_rdata = countHigh[1];
        dual_timer_pkg::ADDR_IRQ_STATUS: next_rdata[1:0] = irqStatus;
        dual_timer_pkg::ADDR_IRQ_MASK: next_rdata[1:0] = irqMask;
        // unmapped offsets read as zero
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // unit 0 checks; unit 1 shares the same logic through the loops

  a_low_increment: assert property (@(posedge clk) disable iff (!rst_n)
    (incEvent[0] && !wr && countLow[0] != 8'hFF) |=> countLow[0] == $past(countLow[0]) + 8'h01)
    else $error("low byte did not advance");

  a_high_carry: assert property (@(posedge clk) disable iff (!rst_n)
    (incEvent[0] && !wr && countLow[0] == 8'hFF) |=>
      (countLow[0] == 8'h00) && (countHigh[0] == $past(countHigh[0]) + 8'h01))
    else $error("high byte did not take the carry");

  a_overflow_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ovfEvent[0] |=> overflowFlag[0] && irqStatus[0] && countHigh[0] == 8'h00)
    else $error("overflow did not set flag");

  a_ack_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (ovfAck[0] && !ovfEvent[0]) |=> !overflowFlag[0])
    else $error("vector did not clear flag");

  a_run_keeps_count: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == dual_timer_pkg::ADDR_TIMER_CTRL && wdata[dual_timer_pkg::RUN0_BIT]
      && !runCtl[0]) |=> $stable(countLow[0]) && $stable(countHigh[0]))
    else $error("starting changed the count");

  a_read_count: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == dual_timer_pkg::ADDR_LOW0) |=> rdata == $past(countLow[0]))
    else $error("count read returned wrong byte");

  a_timer_tick: assert property (@(posedge clk) disable iff (!rst_n)
    (runCtl[0] && !gateEn[0] && !counterSel[0]) |-> incEvent[0] == perTick[0])
    else $error("timer mode missed a peripheral cycle");

  a_falling_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (incEvent[0] && counterSel[0]) |-> (prevSample[0] && !countLevel[0]))
    else $error("counter stepped without a falling edge");

  a_gate_block: assert property (@(posedge clk) disable iff (!rst_n)
    (gateEn[0] && !gateLevel[0]) |-> !incEvent[0])
    else $error("gated unit counted");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    ovfEvent[0] && irqMask[0] |=> irq)
    else $error("overflow did not raise interrupt");

  // status clears on a written one unless an overflow lands with it
  a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == dual_timer_pkg::ADDR_IRQ_STATUS && wdata[0] && !ovfEvent[0])
      |=> !irqStatus[0])
    else $error("status write did not clear");

  // a stopped unit with no preset write holds its count
  a_stopped_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!runCtl[0] && !wr) |=> $stable(countLow[0]) && $stable(countHigh[0]))
    else $error("stopped unit changed its count");

  // read data stands one cycle only, zero otherwise
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !rd |=> rdata == 8'h00)
    else $error("read data stood without a read");

endmodule

// file: event_source.sv
// event source model: drives one external count pin with a burst of pulses.
// assumes the bench raises start for one clock while the model is idle.
`timescale 1ns/1ps
module event_source (
  input wire clk,
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic [7:0] halfLen,
  output logic pin,
  output logic busy
);
  // pin idles high so the first low level is a genuine falling edge
  initial begin
    pin = 1'b1;
    busy = 1'b0;
  end

  // level held long
  // each level stands halfLen clocks; the bench never asks for less
  // than one peripheral cycle, so every level is sampled at least once
  always @(posedge clk) begin
    if (start) begin
      busy <= 1'b1;
      for (int i = 0; i < pulses; i++) begin
        pin <= 1'b0;
        repeat (halfLen) @(posedge clk);
        pin <= 1'b1;
        repeat (halfLen) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// file: testbench.sv
// self-checking bench for the dual timer/counter.
// assumes 25 MHz clk, registers on the plain strobe port, and two
// event_source models on the count pins.
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic rst_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [1:0] countPin;
  logic [1:0] extIntPin;
  logic [1:0] ovfAck;
  logic [1:0] overflowFlag;
  logic irq;
  // partner controls, one slot per unit
  logic [1:0] srcStart;
  logic [1:0] srcBusy;
  logic [7:0] srcPulses [2];
  logic [7:0] srcHalf [2];
  int fails;
  int totalChecks;

  dual_timer uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .countPin(countPin), .extIntPin(extIntPin), .ovfAck(ovfAck),
    .overflowFlag(overflowFlag), .irq(irq));

  // one event source per count pin
  for (genvar u = 0; u < 2; u++) begin : g_src
    event_source src (.clk(clk), .start(srcStart[u]), .pulses(srcPulses[u]),
      .halfLen(srcHalf[u]), .pin(countPin[u]), .busy(srcBusy[u]));
  end

  // free-running 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    if (fails == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one-cycle write strobe, launched right after an edge
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe is taken
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, d);
    check("register", {8'h00, exp}, {8'h00, d});
  endtask

  // counts are written only while the unit is stopped
  task automatic set_count(input int u, input logic [15:0] v);
    reg_write(u == 0 ? dual_timer_pkg::ADDR_LOW0 : dual_timer_pkg::ADDR_LOW1, v[7:0]);
    reg_write(u == 0 ? dual_timer_pkg::ADDR_HIGH0 : dual_timer_pkg::ADDR_HIGH1, v[15:8]);
  endtask

  task automatic expect_count(input int u, input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    reg_read(u == 0 ? dual_timer_pkg::ADDR_LOW0 : dual_timer_pkg::ADDR_LOW1, lo);
    reg_read(u == 0 ? dual_timer_pkg::ADDR_HIGH0 : dual_timer_pkg::ADDR_HIGH1, hi);
    check("count", exp, {hi, lo});
  endtask

  // run bits stay set for exactly cycles clocks, so a window of N
  // peripheral cycles always holds N ticks whatever the prescaler phase
  task automatic run_for(input logic [7:0] runBits, input int cycles);
    reg_write(dual_timer_pkg::ADDR_TIMER_CTRL, runBits);
    repeat (cycles - 2) @(posedge clk);
    reg_write(dual_timer_pkg::ADDR_TIMER_CTRL, 8'h00);
  endtask

  // let registered outputs settle before looking at them
  task automatic expect_pins(input logic [1:0] expFlag, input logic expIrq);
    repeat (2) @(posedge clk);
    #1;
    check("overflowFlag", {14'h0000, expFlag}, {14'h0000, overflowFlag});
    check("irq", {15'h0000, expIrq}, {15'h0000, irq});
  endtask

  task automatic pulse_ack(input logic [1:0] which);
    @(posedge clk);
    ovfAck <= which;
    @(posedge clk);
    ovfAck <= 2'b00;
  endtask

  // every mapped place reads zero after reset; unmapped ones stay zero
  task automatic test_reset();
    for (int a = 0; a < 10; a++) begin
      expect_reg(4'(a), 8'h00);
    end
    reg_write(4'hF, 8'hFF);
    expect_reg(4'hF, 8'h00);
    expect_pins(2'b00, 1'b0);
  endtask

  // preset survives start, carry from low to high, one count per 12 clk
  task automatic test_timer();
    set_count(0, 16'h12FE);
    run_for(8'h10, 36);
    expect_count(0, 16'h1301);
    expect_count(1, 16'h0000);
  endtask

  // double speed halves unit 0 period; unit 1 rate bit pins it to clk/2
  task automatic test_rate();
    set_count(0, 16'h0000);
    reg_write(dual_timer_pkg::ADDR_CLOCK_CTRL, 8'h06);
    run_for(8'h50, 120);
    expect_count(0, 16'h0014);
    expect_count(1, 16'h000A);
    reg_write(dual_timer_pkg::ADDR_CLOCK_CTRL, 8'h00);
  endtask

  // overflow sets flag and status; ack clears flag, W1C clears status
  task automatic test_overflow();
    reg_write(dual_timer_pkg::ADDR_IRQ_MASK, 8'h01);
    set_count(0, 16'hFFFF);
    run_for(8'h10, 12);
    expect_count(0, 16'h0000);
    expect_pins(2'b01, 1'b1);
    expect_reg(dual_timer_pkg::ADDR_TIMER_CTRL, 8'h20);
    expect_reg(dual_timer_pkg::ADDR_IRQ_STATUS, 8'h01);
    pulse_ack(2'b01);
    expect_pins(2'b00, 1'b1);
    reg_write(dual_timer_pkg::ADDR_IRQ_STATUS, 8'h01);
    expect_pins(2'b00, 1'b0);
    // unit 1 overflows while masked out, then the mask lets it through
    set_count(1, 16'hFFFF);
    run_for(8'h40, 12);
    expect_pins(2'b10, 1'b0);
    reg_write(dual_timer_pkg::ADDR_IRQ_MASK, 8'h03);
    expect_pins(2'b10, 1'b1);
    pulse_ack(2'b10);
    reg_write(dual_timer_pkg::ADDR_IRQ_STATUS, 8'h02);
    expect_pins(2'b00, 1'b0);
  endtask

  // gate on: pin low blocks counting, pin high lets it run
  task automatic test_gate();
    reg_write(dual_timer_pkg::ADDR_MODE, 8'h02);
    set_count(0, 16'h0000);
    run_for(8'h10, 24);
    expect_count(0, 16'h0000);
    @(posedge clk);
    extIntPin <= 2'b01;
    repeat (8) @(posedge clk);
    run_for(8'h10, 24);
    expect_count(0, 16'h0002);
    reg_write(dual_timer_pkg::ADDR_MODE, 8'h00);
    @(posedge clk);
    extIntPin <= 2'b00;
    repeat (8) @(posedge clk);
    run_for(8'h10, 24);
    expect_count(0, 16'h0004);
  endtask

  // counter mode: unit 0 at the fastest legal rate, unit 1 slower
  task automatic test_counter();
    reg_write(dual_timer_pkg::ADDR_MODE, 8'h05);
    set_count(0, 16'h0000);
    reg_write(dual_timer_pkg::ADDR_TIMER_CTRL, 8'h50);
    @(posedge clk);
    srcPulses[0] <= 8'h05;
    srcHalf[0] <= 8'h0C;
    srcPulses[1] <= 8'h07;
    srcHalf[1] <= 8'h14;
    srcStart <= 2'b11;
    @(posedge clk);
    srcStart <= 2'b00;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 1000 && srcBusy !== 2'b00; i++) begin
      @(posedge clk);
    end
    check("srcBusy", 16'h0000, {14'h0000, srcBusy});
    // allow the pin synchroniser and edge sampler to catch up
    repeat (30) @(posedge clk);
    reg_write(dual_timer_pkg::ADDR_TIMER_CTRL, 8'h00);
    expect_count(0, 16'h0005);
    expect_count(1, 16'h0007);
    reg_write(dual_timer_pkg::ADDR_MODE, 8'h00);
  endtask

  // main sequence: reset, then every scenario in turn
  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    extIntPin = 2'b00;
    ovfAck = 2'b00;
    srcStart = 2'b00;
    srcPulses[0] = 8'h00;
    srcPulses[1] = 8'h00;
    srcHalf[0] = 8'h01;
    srcHalf[1] = 8'h01;
    fails = 0;
    totalChecks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_timer();
    test_rate();
    test_overflow();
    test_gate();
    test_counter();
    finish_test();
  end

  // watchdog: the scenarios need a few thousand clocks at most
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule
